// ---- include/ptr_mbox_pkg.sv ----
package ptr_mbox_pkg;

  // ****************************************
  // register indices and byte addresses
  // ****************************************
  localparam int ADDR_W = 16;
  localparam logic [11:0] IDX_POINTER_OP_CONTROL = 12'h102;
  localparam logic [11:0] IDX_MAILBOX_ADDRESS_WINDOW = 12'h103;
  localparam logic [11:0] IDX_ABUS_MODE_CONTROL = 12'h106;
  localparam logic [ADDR_W-1:0] ADDR_POINTER_OP_CONTROL =
    {2'h0, IDX_POINTER_OP_CONTROL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_MAILBOX_ADDRESS_WINDOW =
    {2'h0, IDX_MAILBOX_ADDRESS_WINDOW, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_ABUS_MODE_CONTROL =
    {2'h0, IDX_ABUS_MODE_CONTROL, 2'h0};

  // ****************************************
  // pointer_op_control field layout
  // ****************************************
  localparam int INDEX_LSB = 0;
  localparam int INDEX_W = 5;
  localparam int DIR_BIT = 5;
  localparam int BP_LSB = 6;
  localparam int BP_W = 2;

  // ****************************************
  // abus_mode_control field layout
  // ****************************************
  localparam int MODE_BIT = 0;
  localparam int NIB_LSB = 4;
  localparam int NIB_W = 4;

  // ****************************************
  // mailbox address layout
  // ****************************************
  localparam int MBOX_W = 28;
  localparam int BYTE_W = 8;
  localparam int NUM_BYTES = 4;
  localparam int ALIGN_W = 2;
  localparam logic [BP_W-1:0] BP_STEP = 2'h1;
  localparam logic [BP_W-1:0] BP_LAST = 2'h3;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  // apb transfer sequencing
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WAIT,
    BUS_DONE
  } bus_state_t;

endpackage : ptr_mbox_pkg

// ---- design/mailbox_byte_bank.sv ----
`timescale 1ns/1ps

module mailbox_byte_bank
  import ptr_mbox_pkg::*;
#(
  parameter logic [MBOX_W-1:0] REVISION_CODE = 28'h0000001
)(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [BP_W-1:0] wr_ptr,
  input wire logic [BYTE_W-1:0] wr_byte,
  output logic [NUM_BYTES*BYTE_W-1:0] bytes_out
);

  // ****************************************
  // four byte registers behind the window
  // ****************************************
  // revision code padded to the full bank width, so every byte is defined
  localparam logic [NUM_BYTES*BYTE_W-1:0] REV_FULL =
    {{(NUM_BYTES*BYTE_W-MBOX_W){1'b0}}, REVISION_CODE};
  // top byte keeps only address bits 27:24, low byte drops the align bits
  localparam logic [BYTE_W-1:0] TOP_MASK = 8'h0F;
  localparam logic [BYTE_W-1:0] ALIGN_MASK = 8'hFC;

  genvar g;
  generate
    for (g = 0; g < NUM_BYTES; g = g + 1) begin : g_byte
      logic [BYTE_W-1:0] byte_reg;
      logic [BYTE_W-1:0] byte_next;
      logic [BP_W-1:0] my_ptr;
      // pointer zero selects the most significant byte
      assign my_ptr = BP_W'(NUM_BYTES - 1 - g);
      // clip bits beyond 28 and the two alignment bits
      always_comb begin
        byte_next = wr_byte;
        if (g == NUM_BYTES - 1) begin
          byte_next = wr_byte & TOP_MASK;
        end
        if (g == 0) begin
          byte_next = wr_byte & ALIGN_MASK;
        end
      end
      // revision code after reset, host bytes afterwards
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          byte_reg <= REV_FULL[g*BYTE_W +: BYTE_W];
        end else if (wr_en && (wr_ptr == my_ptr)) begin
          byte_reg <= byte_next;
        end
      end
      assign bytes_out[g*BYTE_W +: BYTE_W] = byte_reg;
    end
  endgenerate

endmodule : mailbox_byte_bank

// ---- design/pointer_ram_mailbox_setup.sv ----
// Register access over APB is this design's own decision.
`timescale 1ns/1ps


module pointer_ram_mailbox_setup
  import ptr_mbox_pkg::*;
#(
  parameter logic [MBOX_W-1:0] REVISION_CODE = 28'h0000001 // arbitrary
)(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NIB_W-1:0] channel_code,
  input wire logic addr_cycle,
  output logic [NIB_W-1:0] upper_addr_nibble,
  output logic [INDEX_W-1:0] pointer_ram_index,
  output logic pointer_op_direction,
  output logic [BP_W-1:0] window_byte_pointer,
  output logic [MBOX_W-1:0] mailbox_address,
  output logic enhanced_addr_bus_select
);

  // ****************************************
  // bus sequencing state
  // ****************************************
  bus_state_t bus_state_reg;
  bus_state_t bus_state_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic pready_reg;

  // ****************************************
  // register contents
  // ****************************************
  logic [INDEX_W-1:0] index_reg;
  logic dir_reg;
  logic [BP_W-1:0] bp_reg;
  logic [BP_W-1:0] bp_next;
  logic mode_reg;
  logic [NIB_W-1:0] nib_reg;
  logic [NIB_W-1:0] upper_nib_reg;
  logic [NUM_BYTES*BYTE_W-1:0] bank_bytes;

  // ****************************************
  // decode of the current request
  // ****************************************
  logic hit_ctl;
  logic hit_win;
  logic hit_abus;
  logic hit_any;
  logic access;
  logic commit;
  logic commit_wr;
  logic commit_rd;
  logic win_wr;
  logic win_touch;
  logic [BYTE_W-1:0] win_rd_byte;

  // address compare against the three mapped words
  always_comb begin
    hit_ctl = 1'b0;
    hit_win = 1'b0;
    hit_abus = 1'b0;
    if (paddr == ADDR_POINTER_OP_CONTROL) begin
      hit_ctl = 1'b1;
    end else if (paddr == ADDR_MAILBOX_ADDRESS_WINDOW) begin
      hit_win = 1'b1;
    end else if (paddr == ADDR_ABUS_MODE_CONTROL) begin
      hit_abus = 1'b1;
    end
  end

  assign hit_any = hit_ctl | hit_win | hit_abus;
  assign access = psel & penable;
  // the edge where pready is seen high completes the transfer
  assign commit = access & pready_reg;
  assign commit_wr = commit & pwrite;
  assign commit_rd = commit & ~pwrite;
  assign win_wr = commit_wr & hit_win;
  assign win_touch = commit & hit_win;

  // ****************************************
  // apb answer sequencing
  // ****************************************

  // idle -> wait (data prepared) -> done (pready up) -> idle
  always_comb begin
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
      BUS_IDLE: begin
        if (access) begin
          bus_state_next = BUS_WAIT;
        end
      end
      BUS_WAIT: begin
        bus_state_next = BUS_DONE;
      end
      BUS_DONE: begin
        bus_state_next = BUS_IDLE;
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  // pready raised for exactly the completing edge
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= (bus_state_next == BUS_DONE);
    end
  end

  // ****************************************
  // read data and error answer
  // ****************************************

  // the window returns the byte under the pointer
  always_comb begin
    win_rd_byte = bank_bytes[(BP_LAST - bp_reg)*BYTE_W +: BYTE_W];
  end

  // read mux, evaluated while the request waits
  always_comb begin
    prdata_next = DATA_ZERO;
    pslverr_next = 1'b0;
    if (!hit_any) begin
      pslverr_next = 1'b1;
    end else if (pwrite) begin
      prdata_next = DATA_ZERO;
    end else if (hit_ctl) begin
      prdata_next[INDEX_LSB +: INDEX_W] = index_reg;
      prdata_next[DIR_BIT] = dir_reg;
      prdata_next[BP_LSB +: BP_W] = bp_reg;
    end else if (hit_win) begin
      prdata_next[BYTE_W-1:0] = win_rd_byte;
    end else begin
      prdata_next[MODE_BIT] = mode_reg;
      prdata_next[NIB_LSB +: NIB_W] = nib_reg;
    end
  end

  // read data and error held for the answer cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata_reg <= DATA_ZERO;
      pslverr_reg <= 1'b0;
    end else if (bus_state_reg == BUS_WAIT) begin
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end else if (bus_state_reg == BUS_DONE) begin
      prdata_reg <= DATA_ZERO;
      pslverr_reg <= 1'b0;
    end
  end

  // ****************************************
  // pointer operation control register
  // ****************************************

  // index and direction keep their value through reset
  always_ff @(posedge clk_sys) begin
    if (commit_wr && hit_ctl) begin
      index_reg <= pwdata[INDEX_LSB +: INDEX_W];
      dir_reg <= pwdata[DIR_BIT];
    end
  end

  // byte pointer: loaded by host, stepped by window access
  always_comb begin
    bp_next = bp_reg;
    if (commit_wr && hit_ctl) begin
      bp_next = pwdata[BP_LSB +: BP_W];
    end else if (win_touch) begin
      bp_next = bp_reg + BP_STEP;
    end
  end

  // no reset branch: the whole register survives reset
  always_ff @(posedge clk_sys) begin
    bp_reg <= bp_next;
  end

  // ****************************************
  // mailbox address window
  // ****************************************

  // byte registers holding the mailbox address or revision code
  mailbox_byte_bank #(
    .REVISION_CODE(REVISION_CODE)
  ) u_bank (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wr_en(win_wr),
    .wr_ptr(bp_reg),
    .wr_byte(pwdata[BYTE_W-1:0]),
    .bytes_out(bank_bytes)
  );

  // ****************************************
  // address bus mode control
  // ****************************************

  // mode select and nibble pattern
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= 1'b0;
      nib_reg <= 4'h0;
    end else if (commit_wr && hit_abus) begin
      mode_reg <= pwdata[MODE_BIT];
      nib_reg <= pwdata[NIB_LSB +: NIB_W];
    end
  end

  // upper nibble loaded during the address cycle, presented one cycle later
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      upper_nib_reg <= 4'h0;
    end else if (!addr_cycle) begin
      upper_nib_reg <= 4'h0;
    end else if (mode_reg) begin
      upper_nib_reg <= nib_reg;
    end else begin
      upper_nib_reg <= channel_code;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign upper_addr_nibble = upper_nib_reg;
  assign pointer_ram_index = index_reg;
  assign pointer_op_direction = dir_reg;
  assign window_byte_pointer = bp_reg;
  // low alignment bits forced to zero on the way out
  assign mailbox_address = {bank_bytes[MBOX_W-1:ALIGN_W],
    {ALIGN_W{1'b0}}};
  assign enhanced_addr_bus_select = mode_reg;

endmodule : pointer_ram_mailbox_setup

// ---- test/ptr_mbox_asserts.sv ----
`timescale 1ns/1ps

module ptr_mbox_asserts
  import ptr_mbox_pkg::*;
#(
  parameter logic [MBOX_W-1:0] REVISION_CODE = 28'h0000001
)(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [NIB_W-1:0] channel_code,
  input wire logic addr_cycle,
  input wire logic [NIB_W-1:0] upper_addr_nibble,
  input wire logic [INDEX_W-1:0] pointer_ram_index,
  input wire logic pointer_op_direction,
  input wire logic [BP_W-1:0] window_byte_pointer,
  input wire logic [MBOX_W-1:0] mailbox_address,
  input wire logic enhanced_addr_bus_select
);
  // ****************************************
  // completed transfer terms
  // ****************************************
  wire logic done = psel && penable && pready;
  wire logic ctl_wr = done && pwrite && paddr == ADDR_POINTER_OP_CONTROL;
  wire logic win = done && paddr == ADDR_MAILBOX_ADDRESS_WINDOW;
  wire logic abus_wr = done && pwrite && paddr == ADDR_ABUS_MODE_CONTROL;
  logic [NIB_W-1:0] pat_seen;
  // pattern the host last stored, for the enhanced mode check
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pat_seen <= 4'h0;
    end else if (abus_wr) begin
      pat_seen <= pwdata[NIB_LSB +: NIB_W];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_index_load: assert property (
    ctl_wr |=> pointer_ram_index == $past(pwdata[4:0]))
    else $error("index field not loaded");
  a_dir_load: assert property (
    ctl_wr |=> pointer_op_direction == $past(pwdata[5]))
    else $error("direction bit not loaded");
  a_bp_load: assert property (
    ctl_wr |=> window_byte_pointer == $past(pwdata[7:6]))
    else $error("byte pointer not loaded");
  a_bp_step: assert property (
    win |=> window_byte_pointer == $past(window_byte_pointer) + BP_STEP)
    else $error("byte pointer did not advance");
  a_mbox_aligned: assert property (
    mailbox_address[1:0] == 2'h0)
    else $error("mailbox address not word aligned");
  a_rev_loaded: assert property (
    $rose(rst_b) |-> mailbox_address == {REVISION_CODE[27:2], 2'h0})
    else $error("revision code not loaded by reset");
  a_mbox_hold: assert property (
    !(win && pwrite) |=> $stable(mailbox_address))
    else $error("mailbox address changed without a write");
  a_ready_lag: assert property (
    psel && $rose(penable) |-> !pready ##1 !pready ##1 pready)
    else $error("ready not two cycles after access");
  a_nib_normal: assert property (
    addr_cycle && !enhanced_addr_bus_select
      |=> upper_addr_nibble == $past(channel_code))
    else $error("channel code not on upper nibble");
  a_nib_idle: assert property (
    !addr_cycle |=> upper_addr_nibble == 4'h0)
    else $error("upper nibble driven outside address cycle");
  a_nib_enhanced: assert property (
    addr_cycle && enhanced_addr_bus_select
      |=> upper_addr_nibble == $past(pat_seen))
    else $error("stored pattern not on upper nibble");
  a_low_byte_write: assert property (
    win && pwrite && window_byte_pointer == BP_LAST
      |=> mailbox_address[7:0] == {$past(pwdata[7:2]), 2'h0})
    else $error("low mailbox byte not written aligned");
endmodule : ptr_mbox_asserts

bind pointer_ram_mailbox_setup ptr_mbox_asserts #(
  .REVISION_CODE(REVISION_CODE)
) chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .channel_code(channel_code), .addr_cycle(addr_cycle),
  .upper_addr_nibble(upper_addr_nibble),
  .pointer_ram_index(pointer_ram_index),
  .pointer_op_direction(pointer_op_direction),
  .window_byte_pointer(window_byte_pointer),
  .mailbox_address(mailbox_address),
  .enhanced_addr_bus_select(enhanced_addr_bus_select)
);

// ---- test/apb_host_model.sv ----
`timescale 1ns/1ps

module apb_host_model
  import ptr_mbox_pkg::*;
(
  input wire logic clk_sys,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  output logic hung
);
  // ****************************************
  // apb master transfers
  // ****************************************
  initial begin
    {psel, penable, pwrite, hung} = 4'h0;
    paddr = 16'h0000;
    pwdata = DATA_ZERO;
  end

  // setup cycle, then access held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) hung <= 1'h1;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer

  // clear the pointer, then four bytes most significant first
  task automatic load_mbox(input logic [5:0] ctl, input logic [27:0] m);
    logic [31:0] w;
    w = {4'h0, m};
    xfer(1'h1, ADDR_POINTER_OP_CONTROL, {24'h0, 2'h0, ctl});
    for (int i = 0; i < 4; i++) begin
      xfer(1'h1, ADDR_MAILBOX_ADDRESS_WINDOW, {24'h0, w[31-8*i -: 8]});
    end
  endtask : load_mbox
endmodule : apb_host_model

// ---- test/testbench.sv ----
`timescale 1ns/1ps

module testbench
  import ptr_mbox_pkg::*;
;
  // ****************************************
  // bench signals and design
  // ****************************************
  localparam logic [27:0] REV = 28'h5A3C1E4; // arbitrary code
  logic clk_sys = 1'h0;
  logic rst_b = 1'h0;
  logic addr_cycle = 1'h0;
  logic [3:0] channel_code = 4'h0;
  logic psel, penable, pwrite, pready, pslverr, hung, mode_sel, dir;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, c, r, mw;
  logic [3:0] nib;
  logic [4:0] idx;
  logic [1:0] bp;
  logic [27:0] mbox;
  logic [31:0] exp_q[$];
  logic err_q[$];
  int error_cnt = 0;
  int checks_done = 0;
  int seed = 62717;

  // 10 MHz system clock
  always #50 clk_sys = ~clk_sys;

  pointer_ram_mailbox_setup #(.REVISION_CODE(REV)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .channel_code(channel_code),
    .addr_cycle(addr_cycle), .upper_addr_nibble(nib),
    .pointer_ram_index(idx), .pointer_op_direction(dir),
    .window_byte_pointer(bp), .mailbox_address(mbox),
    .enhanced_addr_bus_select(mode_sel));

  apb_host_model host (
    .clk_sys(clk_sys), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .hung(hung));

  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : cmp

  task automatic end_sim;
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // note the expected read data, then run the read
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    // an address outside the three mapped words must be refused
    err_q.push_back(!(a inside {ADDR_POINTER_OP_CONTROL,
      ADDR_MAILBOX_ADDRESS_WINDOW, ADDR_ABUS_MODE_CONTROL}));
    host.xfer(1'h0, a, DATA_ZERO);
  endtask : rd

  // set the pointer to zero and read four window bytes
  task automatic win_rd(input logic [27:0] v);
    host.xfer(1'h1, ADDR_POINTER_OP_CONTROL, {24'h0, 2'h0, c[5:0]});
    mw = {4'h0, v};
    for (int i = 0; i < 4; i++) begin
      rd(ADDR_MAILBOX_ADDRESS_WINDOW, {24'h0, mw[31-8*i -: 8]});
    end
  endtask : win_rd

  // read data checker fed from the note queue
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'h1 && !pwrite) begin
      cmp("prdata", exp_q.pop_front(), prdata);
      cmp("pslverr", {31'h0, err_q.pop_front()}, {31'h0, pslverr});
    end
  end

  // a hung transfer ends the run
  always @(posedge hung) begin
    error_cnt++;
    end_sim();
  end

  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'h1;
    c = $random(seed);
    host.xfer(1'h1, ADDR_POINTER_OP_CONTROL, {24'h0, 2'h0, c[5:0]});
    #1 cmp("index", {27'h0, c[4:0]}, {27'h0, idx});
    cmp("direction", {31'h0, c[5]}, {31'h0, dir});
    win_rd(REV);
    #1 cmp("pointer", 32'h0, {30'h0, bp});
    repeat (2) begin
      r = $random(seed);
      host.load_mbox(c[5:0], r[27:0]);
      #1 cmp("mailbox", {4'h0, r[27:2], 2'h0}, {4'h0, mbox});
      win_rd({r[27:2], 2'h0});
    end
    host.xfer(1'h1, ADDR_POINTER_OP_CONTROL, {24'h0, 2'h3, c[5:0]});
    host.xfer(1'h1, ADDR_MAILBOX_ADDRESS_WINDOW, 32'h0000_00FF);
    #1 cmp("low byte", {4'h0, r[27:8], 8'hFC}, {4'h0, mbox});
    cmp("pointer", 32'h0, {30'h0, bp});
    @(posedge clk_sys);
    rst_b <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'h1;
    rd(ADDR_POINTER_OP_CONTROL, {24'h0, 2'h0, c[5:0]});
    win_rd(REV);
    rd(16'h0500, DATA_ZERO);
    for (int e = 0; e < 2; e++) begin
      host.xfer(1'h1, ADDR_ABUS_MODE_CONTROL, {24'h0, 4'hA, 3'h0, e[0]});
      rd(ADDR_ABUS_MODE_CONTROL, {24'h0, 4'hA, 3'h0, e[0]});
      r = $random(seed);
      channel_code <= r[3:0];
      addr_cycle <= 1'h1;
      @(posedge clk_sys);
      addr_cycle <= 1'h0;
      #1 cmp("nibble", {28'h0, e[0] ? 4'hA : r[3:0]}, {28'h0, nib});
      cmp("mode bit", {31'h0, e[0]}, {31'h0, mode_sel});
      @(posedge clk_sys);
      #1 cmp("idle nibble", 32'h0, {28'h0, nib});
    end
    end_sim();
  end
endmodule : testbench
